// ==== verilog/hlu_uart_defs.vh ====
// Constants for the host link serial port with hardware flow control.
// Assumes a single 20 MHz clock and plain Verilog-2005 consumers.
`ifndef HLU_UART_DEFS_VH
`define HLU_UART_DEFS_VH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define HLU_CLK_KHZ        20000
`define HLU_POWERUP_MS     100
`define HLU_MIN_BAUD_BPS   37500
`define HLU_MAX_BAUD_BPS   4000000
`define HLU_CLKS_PER_BIT   174
`define HLU_CNT_W          16
`define HLU_PU_W           22

// ----------------------------------------------------------------
// Frame and buffering
// ----------------------------------------------------------------
`define HLU_DATA_BITS      8
`define HLU_RX_DEPTH       64
`define HLU_RX_AW          6
`define HLU_RX_THRESH_DIV  4
`define HLU_RX_LATE_BYTES  16

// ----------------------------------------------------------------
// State codes, shared by transmitter and receiver
// ----------------------------------------------------------------
`define HLU_ST_IDLE        3'h0
`define HLU_ST_START       3'h1
`define HLU_ST_DATA        3'h2
`define HLU_ST_PAR         3'h3
`define HLU_ST_STOP        3'h4

`endif

// ==== verilog/hlu_pair_buf.v ====
// Two-entry valid/ready buffer between the user and the transmitter.
// Assumes both sides run on clk; a stalled drain fills it and drops in_ready.

module hlu_pair_buf #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rstn,
  input  wire             clr,
  // Filling side
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  // Draining side
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);

  reg [WIDTH-1:0] mem_reg [0:1];
  reg             wptr_reg;
  reg             rptr_reg;
  reg [1:0]       count_reg;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  // Honest flags straight from the fill count
  assign in_ready  = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data  = mem_reg[rptr_reg];

  // Pointers and count; clr empties it when the port powers down
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wptr_reg  <= 1'b0;
      rptr_reg  <= 1'b0;
      count_reg <= 2'h0;
    end else if (clr) begin
      wptr_reg  <= 1'b0;
      rptr_reg  <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (push)
        wptr_reg <= ~wptr_reg;
      if (pop)
        rptr_reg <= ~rptr_reg;
      if (push & ~pop)
        count_reg <= count_reg + 2'h1;
      else if (pop & ~push)
        count_reg <= count_reg - 2'h1;
    end
  end

  // Storage needs no reset; out_valid guards it
  always @(posedge clk) begin
    if (push)
      mem_reg[wptr_reg] <= in_data;
  end

endmodule // hlu_pair_buf

// ==== verilog/hlu_uart.v ====
// Device end of the host serial link: transmitter, receiver, receive store,
// request/clear flow control and power-up sequencing.
// Assumes clk at 20 MHz; every incoming link pin is asynchronous and synchronised here.

`include "hlu_uart_defs.vh"

module hlu_uart #(
  parameter CLKS_PER_BIT   = `HLU_CLKS_PER_BIT,
  parameter DATA_BITS      = `HLU_DATA_BITS,
  parameter PARITY_EN      = 0,
  parameter PARITY_ODD     = 0,
  parameter RX_DEPTH       = `HLU_RX_DEPTH,
  parameter RX_AW          = `HLU_RX_AW,
  parameter POWERUP_CYCLES = `HLU_POWERUP_MS * `HLU_CLK_KHZ
) (
  // Clock and reset
  input  wire                 clk,
  input  wire                 rstn,
  // Power control pin
  input  wire                 power_down_request_n,
  // Link pins, output enables active low
  input  wire                 host_link_receive_pin,
  input  wire                 host_link_clear_pin,
  output wire                 host_link_transmit_pin,
  output wire                 host_link_transmit_oe_n,
  output wire                 host_link_request_pin,
  output wire                 host_link_request_oe_n,
  // Bytes to send
  input  wire [DATA_BITS-1:0] tx_data,
  input  wire                 tx_valid,
  output wire                 tx_ready,
  // Bytes received
  output wire [DATA_BITS-1:0] rx_data,
  output wire                 rx_valid,
  input  wire                 rx_ready,
  // Status
  output wire                 link_ready,
  output wire                 rx_frame_error,
  output wire                 rx_parity_error,
  output wire                 rx_overrun
);

  localparam [`HLU_CNT_W-1:0] BIT_LAST  = CLKS_PER_BIT - 1;
  localparam [`HLU_CNT_W-1:0] HALF_LAST = CLKS_PER_BIT / 2 - 1;
  localparam [`HLU_PU_W-1:0]  PU_LAST   = POWERUP_CYCLES - 1;
  localparam [RX_AW:0]        RX_THRESH = RX_DEPTH / `HLU_RX_THRESH_DIV;
  localparam [RX_AW:0]        RX_FULL   = RX_DEPTH;
  localparam [3:0]            BIT_TOP   = DATA_BITS - 1;

  // ----------------------------------------------------------------
  // Parity, used by both directions
  // ----------------------------------------------------------------
  function par_of;
    input [DATA_BITS-1:0] d;
    begin
      par_of = (^d) ^ (PARITY_ODD != 0);
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg pdn_s1_reg, pdn_s2_reg;
  reg rxp_s1_reg, rxp_s2_reg;
  reg cts_s1_reg, cts_s2_reg;

  // Link idle levels are high, so receive and clear come out of reset as idle; power-down reads as requested
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pdn_s1_reg <= 1'b0;
      pdn_s2_reg <= 1'b0;
      rxp_s1_reg <= 1'b1;
      rxp_s2_reg <= 1'b1;
      cts_s1_reg <= 1'b1;
      cts_s2_reg <= 1'b1;
    end else begin
      pdn_s1_reg <= power_down_request_n;
      pdn_s2_reg <= pdn_s1_reg;
      rxp_s1_reg <= host_link_receive_pin;
      rxp_s2_reg <= rxp_s1_reg;
      cts_s1_reg <= host_link_clear_pin;
      cts_s2_reg <= cts_s1_reg;
    end
  end

  wire srst = ~pdn_s2_reg;

  // ----------------------------------------------------------------
  // Power-up sequencing
  // ----------------------------------------------------------------
  reg [`HLU_PU_W-1:0] pu_cnt_reg;
  reg                 ready_reg;

  // Port stays dark until the count expires after release
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pu_cnt_reg <= {`HLU_PU_W{1'b0}};
      ready_reg  <= 1'b0;
    end else if (srst) begin
      pu_cnt_reg <= {`HLU_PU_W{1'b0}};
      ready_reg  <= 1'b0;
    end else if (!ready_reg) begin
      if (pu_cnt_reg == PU_LAST)
        ready_reg <= 1'b1;
      else
        pu_cnt_reg <= pu_cnt_reg + 1'b1;
    end
  end

  assign link_ready = ready_reg;
  wire   halt       = srst | ~ready_reg;

  // ----------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------
  wire [DATA_BITS-1:0] buf_data;
  wire                 buf_valid;
  wire                 tx_take;

  hlu_pair_buf #(.WIDTH(DATA_BITS)) u_tx_buf (
    .clk       (clk),
    .rstn      (rstn),
    .clr       (halt),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (tx_take)
  );

  reg [2:0]            tx_state_reg;
  reg [`HLU_CNT_W-1:0] tx_cnt_reg;
  reg [3:0]            tx_bit_reg;
  reg [DATA_BITS-1:0]  tx_shift_reg;
  reg                  tx_par_reg;
  reg                  tx_line_reg;

  wire tx_tick = (tx_cnt_reg == {`HLU_CNT_W{1'b0}});

  // Only between characters is the clear line looked at, so a frame in
  // flight always completes cleanly before the pause
  assign tx_take = (tx_state_reg == `HLU_ST_IDLE) & ~halt & buf_valid
                 & ~cts_s2_reg;

  // Character framer, bit timing from the down-counter
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_state_reg <= `HLU_ST_IDLE;
      tx_cnt_reg   <= {`HLU_CNT_W{1'b0}};
      tx_bit_reg   <= 4'h0;
      tx_shift_reg <= {DATA_BITS{1'b0}};
      tx_par_reg   <= 1'b0;
      tx_line_reg  <= 1'b1;
    end else if (halt) begin
      tx_state_reg <= `HLU_ST_IDLE;
      tx_cnt_reg   <= {`HLU_CNT_W{1'b0}};
      tx_line_reg  <= 1'b1;
    end else begin
      if (tx_state_reg != `HLU_ST_IDLE)
        tx_cnt_reg <= tx_tick ? BIT_LAST : tx_cnt_reg - 1'b1;
      case (tx_state_reg)
        `HLU_ST_IDLE: begin
          if (tx_take) begin
            tx_shift_reg <= buf_data;
            tx_par_reg   <= par_of(buf_data);
            tx_line_reg  <= 1'b0;
            tx_cnt_reg   <= BIT_LAST;
            tx_state_reg <= `HLU_ST_START;
          end
        end
        `HLU_ST_START: begin
          if (tx_tick) begin
            tx_line_reg  <= tx_shift_reg[0];      // LSB first
            tx_shift_reg <= tx_shift_reg >> 1;
            tx_bit_reg   <= 4'h0;
            tx_state_reg <= `HLU_ST_DATA;
          end
        end
        `HLU_ST_DATA: begin
          if (tx_tick) begin
            if (tx_bit_reg == BIT_TOP) begin
              if (PARITY_EN != 0) begin
                tx_line_reg  <= tx_par_reg;
                tx_state_reg <= `HLU_ST_PAR;
              end else begin
                tx_line_reg  <= 1'b1;
                tx_state_reg <= `HLU_ST_STOP;
              end
            end else begin
              tx_line_reg  <= tx_shift_reg[0];
              tx_shift_reg <= tx_shift_reg >> 1;
              tx_bit_reg   <= tx_bit_reg + 4'h1;
            end
          end
        end
        `HLU_ST_PAR: begin
          if (tx_tick) begin
            tx_line_reg  <= 1'b1;
            tx_state_reg <= `HLU_ST_STOP;
          end
        end
        `HLU_ST_STOP: begin
          if (tx_tick)
            tx_state_reg <= `HLU_ST_IDLE;
        end
        default: tx_state_reg <= `HLU_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------
  reg [2:0]            rx_state_reg;
  reg [`HLU_CNT_W-1:0] rx_cnt_reg;
  reg [3:0]            rx_bit_reg;
  reg [DATA_BITS-1:0]  rx_shift_reg;
  reg                  rx_perr_reg;
  reg                  ferr_reg;
  reg                  perr_out_reg;
  reg                  ovr_reg;
  reg [RX_AW:0]        fill_reg;

  wire rx_tick  = (rx_cnt_reg == {`HLU_CNT_W{1'b0}});
  wire rx_full  = (fill_reg == RX_FULL);
  wire rx_good  = (rx_state_reg == `HLU_ST_STOP) & rx_tick & rxp_s2_reg;
  wire rx_push  = rx_good & ~rx_full;

  // Start edge restarts the phase, so every bit is sampled mid-period and
  // per-bit drift never accumulates past one character
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_state_reg <= `HLU_ST_IDLE;
      rx_cnt_reg   <= {`HLU_CNT_W{1'b0}};
      rx_bit_reg   <= 4'h0;
      rx_shift_reg <= {DATA_BITS{1'b0}};
      rx_perr_reg  <= 1'b0;
      ferr_reg     <= 1'b0;
      perr_out_reg <= 1'b0;
      ovr_reg      <= 1'b0;
    end else if (halt) begin
      rx_state_reg <= `HLU_ST_IDLE;
      rx_cnt_reg   <= {`HLU_CNT_W{1'b0}};
      ferr_reg     <= 1'b0;
      perr_out_reg <= 1'b0;
      ovr_reg      <= 1'b0;
    end else begin
      ferr_reg     <= 1'b0;
      perr_out_reg <= 1'b0;
      ovr_reg      <= 1'b0;
      if (rx_state_reg != `HLU_ST_IDLE)
        rx_cnt_reg <= rx_tick ? BIT_LAST : rx_cnt_reg - 1'b1;
      case (rx_state_reg)
        `HLU_ST_IDLE: begin
          if (!rxp_s2_reg) begin
            rx_cnt_reg   <= HALF_LAST;            // mid-bit
            rx_state_reg <= `HLU_ST_START;
          end
        end
        `HLU_ST_START: begin
          if (rx_tick) begin
            rx_bit_reg   <= 4'h0;
            rx_perr_reg  <= 1'b0;
            // Glitch rejection: start must still be low mid-bit
            rx_state_reg <= rxp_s2_reg ? `HLU_ST_IDLE : `HLU_ST_DATA;
          end
        end
        `HLU_ST_DATA: begin
          if (rx_tick) begin
            rx_shift_reg <= {rxp_s2_reg, rx_shift_reg[DATA_BITS-1:1]};
            rx_bit_reg   <= rx_bit_reg + 4'h1;
            if (rx_bit_reg == BIT_TOP)
              rx_state_reg <= (PARITY_EN != 0) ? `HLU_ST_PAR : `HLU_ST_STOP;
          end
        end
        `HLU_ST_PAR: begin
          if (rx_tick) begin
            rx_perr_reg  <= rxp_s2_reg ^ par_of(rx_shift_reg);
            rx_state_reg <= `HLU_ST_STOP;
          end
        end
        `HLU_ST_STOP: begin
          if (rx_tick) begin
            ferr_reg     <= ~rxp_s2_reg;
            perr_out_reg <= rxp_s2_reg & rx_perr_reg;
            ovr_reg      <= rx_good & rx_full;
            rx_state_reg <= `HLU_ST_IDLE;
          end
        end
        default: rx_state_reg <= `HLU_ST_IDLE;
      endcase
    end
  end

  assign rx_frame_error  = ferr_reg;
  assign rx_parity_error = perr_out_reg;
  assign rx_overrun      = ovr_reg;

  // ----------------------------------------------------------------
  // Receive store and output stage
  // ----------------------------------------------------------------
  reg [DATA_BITS-1:0] rx_mem_reg [0:RX_DEPTH-1];
  reg [RX_AW-1:0]     wptr_reg;
  reg [RX_AW-1:0]     rptr_reg;
  reg [DATA_BITS-1:0] rx_data_reg;
  reg                 rx_valid_reg;
  reg                 rts_reg;

  wire rx_pop = (fill_reg != {(RX_AW+1){1'b0}}) & (~rx_valid_reg | rx_ready);

  // Threshold leaves three quarters free for bytes still in flight
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wptr_reg     <= {RX_AW{1'b0}};
      rptr_reg     <= {RX_AW{1'b0}};
      fill_reg     <= {(RX_AW+1){1'b0}};
      rx_data_reg  <= {DATA_BITS{1'b0}};
      rx_valid_reg <= 1'b0;
      rts_reg      <= 1'b1;
    end else if (halt) begin
      wptr_reg     <= {RX_AW{1'b0}};
      rptr_reg     <= {RX_AW{1'b0}};
      fill_reg     <= {(RX_AW+1){1'b0}};
      rx_valid_reg <= 1'b0;
      // High only in power-down; low while counting, so it reads low once driven
      rts_reg      <= srst;
    end else begin
      if (rx_push)
        wptr_reg <= wptr_reg + 1'b1;
      if (rx_pop) begin
        rptr_reg    <= rptr_reg + 1'b1;
        rx_data_reg <= rx_mem_reg[rptr_reg];
      end
      if (rx_pop)
        rx_valid_reg <= 1'b1;
      else if (rx_ready)
        rx_valid_reg <= 1'b0;
      if (rx_push & ~rx_pop)
        fill_reg <= fill_reg + 1'b1;
      else if (rx_pop & ~rx_push)
        fill_reg <= fill_reg - 1'b1;
      rts_reg <= (fill_reg >= RX_THRESH);
    end
  end

  // Store array, no reset needed
  always @(posedge clk) begin
    if (rx_push)
      rx_mem_reg[wptr_reg] <= rx_shift_reg;
  end

  assign rx_data  = rx_data_reg;
  assign rx_valid = rx_valid_reg;

  // ----------------------------------------------------------------
  // Pin drivers: float until powered up, external pulls hold them high
  // ----------------------------------------------------------------
  assign host_link_transmit_pin  = tx_line_reg;
  assign host_link_transmit_oe_n = ~ready_reg;
  assign host_link_request_pin   = rts_reg;
  assign host_link_request_oe_n  = ~ready_reg;

endmodule // hlu_uart

// ==== tb/hlu_uart_checker.sv ====
// Checker for the host serial link: framing, clear/request lines, power-up.
// Assumes CLKS_PER_BIT = 8, eight data bits, no parity, one stop bit.
module hlu_uart_checker #(
  parameter int DATA_BITS      = 8,
  parameter int POWERUP_CYCLES = 50
) (
  // Clock, reset and power
  input wire logic                 clk,
  input wire logic                 rstn,
  input wire logic                 power_down_request_n,
  // Link pins and user side
  input wire logic                 host_link_clear_pin,
  input wire logic                 host_link_transmit_pin,
  input wire logic                 host_link_transmit_oe_n,
  input wire logic                 host_link_request_pin,
  input wire logic                 host_link_request_oe_n,
  input wire logic                 tx_ready,
  input wire logic [DATA_BITS-1:0] rx_data,
  input wire logic                 rx_valid,
  input wire logic                 rx_ready,
  input wire logic                 link_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  fc_reg;
  logic [3:0]  clr_reg;
  logic [15:0] pu_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // -----------------------------------------------
  // Helper counters
  // -----------------------------------------------
  // Position in outgoing character, clear-high run, cycles since power release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fc_reg  <= 8'h00;
      clr_reg <= 4'h0;
      pu_reg  <= 16'h0000;
    end else begin
      if (fc_reg != 8'h00)
        fc_reg <= (fc_reg == 8'h4f) ? 8'h00 : fc_reg + 8'h01;
      else if (link_ready && !host_link_transmit_pin)
        fc_reg <= 8'h01;
      clr_reg <= !host_link_clear_pin ? 4'h0 : clr_reg + {3'h0, clr_reg != 4'hf};
      pu_reg  <= !power_down_request_n ? 16'h0000 : pu_reg + {15'h0000, pu_reg != 16'hffff};
    end
  end

  // Steps of a character and of a held power-down
  sequence s_char_start;
    fc_reg == 8'h00 && link_ready && !host_link_transmit_pin;
  endsequence
  sequence s_pd_held;
    !power_down_request_n [*4];
  endsequence

  property p_float;
    !link_ready |-> host_link_transmit_oe_n && host_link_request_oe_n && host_link_transmit_pin;
  endproperty
  property p_start;
    s_char_start |-> !host_link_transmit_pin [*8];
  endproperty
  property p_stop;
    s_char_start |-> ##72 host_link_transmit_pin [*8];
  endproperty
  property p_cts_stop;
    fc_reg == 8'h00 && host_link_transmit_pin && clr_reg >= 4'h6 |=> host_link_transmit_pin;
  endproperty
  property p_cts_go;
    $fell(host_link_clear_pin) && fc_reg == 8'h00 && !tx_ready && link_ready
      |-> ##[1:10] !host_link_transmit_pin;
  endproperty
  property p_ready_time;
    $rose(link_ready) |-> pu_reg >= POWERUP_CYCLES && pu_reg <= POWERUP_CYCLES + 6
      && !host_link_request_pin && !host_link_request_oe_n;
  endproperty
  property p_rx_hold;
    rx_valid && !rx_ready && power_down_request_n |=> rx_valid && $stable(rx_data);
  endproperty
  property p_pd;
    s_pd_held |=> host_link_transmit_oe_n && host_link_request_oe_n && !link_ready;
  endproperty

  a_float: assert property (p_float)
    else $error("link pins driven before ready");
  a_start: assert property (p_start)
    else $error("start bit too short");
  a_stop: assert property (p_stop)
    else $error("stop bit missing");
  a_cts_stop: assert property (p_cts_stop)
    else $error("character started while clear high");
  a_cts_go: assert property (p_cts_go)
    else $error("no start after clear low");
  a_ready_time: assert property (p_ready_time)
    else $error("power-up timing wrong");
  a_rx_hold: assert property (p_rx_hold)
    else $error("received byte lost while stalled");
  a_pd: assert property (p_pd)
    else $error("pins not floating in power-down");
endmodule // hlu_uart_checker

bind hlu_uart hlu_uart_checker #(.DATA_BITS(DATA_BITS), .POWERUP_CYCLES(POWERUP_CYCLES)) chk_u (
  .clk(clk), .rstn(rstn), .power_down_request_n(power_down_request_n),
  .host_link_clear_pin(host_link_clear_pin), .host_link_transmit_pin(host_link_transmit_pin),
  .host_link_transmit_oe_n(host_link_transmit_oe_n), .host_link_request_pin(host_link_request_pin),
  .host_link_request_oe_n(host_link_request_oe_n), .tx_ready(tx_ready), .rx_data(rx_data),
  .rx_valid(rx_valid), .rx_ready(rx_ready), .link_ready(link_ready));

// ==== tb/hlu_host_model.sv ====
// Host end of the serial link: sends characters and collects the device's.
// Assumes the bench resolves released device pins to their pull-up level.
module hlu_host_model #(
  parameter int BIT = 8
) (
  // Clock and link lines
  input  wire logic clk,
  input  wire logic dev_tx,
  input  wire logic dev_req,
  output logic      host_tx
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  int         bad_stop = 0;

  // -----------------------------------------------
  // Sender
  // -----------------------------------------------
  initial host_tx = 1'b1;

  // A low stop is cut short so the receiver cannot mistake it for a start
  task automatic send(input logic [7:0] b, input logic stop_v, input bit obey);
    if (obey) wait (dev_req === 1'b0);
    repeat (BIT) @(posedge clk) host_tx <= 1'b0;
    for (int i = 0; i < 8; i++) repeat (BIT) @(posedge clk) host_tx <= b[i];
    repeat (stop_v ? BIT : 6) @(posedge clk) host_tx <= stop_v;
    repeat (BIT) @(posedge clk) host_tx <= 1'b1;
  endtask

  // Mid-bit sampling of each device character
  always begin : rx_loop
    logic [7:0] b;
    @(negedge dev_tx);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      b[i] = dev_tx;
    end
    repeat (BIT) @(posedge clk);
    if (dev_tx !== 1'b1) bad_stop++;
    got.push_back(b);
  end
endmodule // hlu_host_model

// ==== tb/tb_top.sv ====
// Bench for the device end of the host serial link with a host model.
// Assumes short bit and power-up counts; released pins float high.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT = 8;
  localparam int PU  = 50;
  logic       clk, rstn, pd_n, clear, tx_valid, rx_ready, host_tx;
  logic [7:0] tx_data, rx_data;
  logic       tx_ready, rx_valid, link_ready, ferr, ovr, perr;
  logic       tx_pin, tx_oe_n, req_pin, req_oe_n;
  wire        tx_line  = tx_oe_n ? 1'b1 : tx_pin; // Pull-ups when released
  wire        req_line = req_oe_n ? 1'b1 : req_pin;
  int         miscompares = 0, total_checks = 0, n_ferr = 0, n_ovr = 0, n_perr = 0;
  logic [7:0] rxq[$];

  // -----------------------------------------------
  // Design, host model, clock and monitors
  // -----------------------------------------------
  hlu_uart #(.CLKS_PER_BIT(BIT), .RX_DEPTH(32), .RX_AW(5), .POWERUP_CYCLES(PU)) dut_u (
    .clk(clk), .rstn(rstn), .power_down_request_n(pd_n), .host_link_receive_pin(host_tx),
    .host_link_clear_pin(clear), .host_link_transmit_pin(tx_pin),
    .host_link_transmit_oe_n(tx_oe_n), .host_link_request_pin(req_pin),
    .host_link_request_oe_n(req_oe_n), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .link_ready(link_ready), .rx_frame_error(ferr), .rx_parity_error(perr), .rx_overrun(ovr));
  hlu_host_model #(.BIT(BIT)) host_u (.clk(clk), .dev_tx(tx_line), .dev_req(req_line),
    .host_tx(host_tx));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Collect accepted bytes and error pulses
  always @(posedge clk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rx_data);
    if (ferr === 1'b1) n_ferr++;
    if (ovr === 1'b1) n_ovr++;
    if (perr !== 1'b0) n_perr++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Leaves tx_valid high so back-to-back bytes need no gap
  task automatic push(input logic [7:0] b);
    int n = 0;
    tx_data  = b;
    tx_valid = 1'b1;
    @(posedge clk);
    while (tx_ready !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    #1;
  endtask

  task automatic wait_got(input int k);
    int n = 0;
    while (host_u.got.size() < k && n < 3000) begin
      @(posedge clk);
      n++;
    end
    #1;
  endtask

  task automatic t_power();
    int n = 0;
    chk({tx_oe_n, req_oe_n, link_ready}, 3'b110);
    while (link_ready !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    #1;
    chk({req_line, req_oe_n, n <= PU + 6}, 3'b001);
    $display("power-up test done");
  endtask

  task automatic t_send();
    logic [7:0] v[4] = '{8'ha5, 8'h00, 8'hff, 8'h3c};
    clear = 1'b0;
    foreach (v[i]) push(v[i]);
    tx_valid = 1'b0;
    wait_got(4);
    foreach (v[i]) chk(host_u.got[i], v[i]);
    chk(host_u.bad_stop, 0);
    host_u.got.delete();
    $display("transmit test done");
  endtask

  // Held off, then released; then clear raised in mid-character
  task automatic t_cts();
    clear = 1'b1;
    tick(100);
    push(8'h11);
    push(8'h22);
    tx_valid = 1'b0;
    tick(2);
    chk(tx_ready, 1'b0); // both entries held
    tick(200);
    chk(host_u.got.size(), 0);
    clear = 1'b0;
    wait_got(2);
    chk({host_u.got[0], host_u.got[1]}, 16'h1122);
    push(8'h5a);
    push(8'h6b);
    tx_valid = 1'b0;
    tick(20);
    clear = 1'b1;
    tick(300);
    chk(host_u.got.size(), 3);
    clear = 1'b0;
    wait_got(4);
    chk({host_u.got[2], host_u.got[3]}, 16'h5a6b);
    $display("clear line test done");
  endtask

  // Good bytes, a framing fault, then recovery
  task automatic t_rx();
    rx_ready = 1'b1;
    rxq.delete();
    host_u.send(8'h81, 1'b1, 1'b1);
    host_u.send(8'h7e, 1'b1, 1'b1);
    host_u.send(8'h99, 1'b0, 1'b1);
    host_u.send(8'hc3, 1'b1, 1'b1);
    tick(20);
    chk(n_ferr, 1);
    chk(rxq.size(), 3);
    chk({rxq[0], rxq[1], rxq[2]}, 24'h817ec3);
    chk(n_perr, 0);
    $display("receive test done");
  endtask

  // Threshold of a quarter of 32 entries, first byte in the output stage;
  // then the full 16 late bytes a host may still send
  task automatic t_rts();
    rx_ready = 1'b0;
    rxq.delete();
    for (int i = 0; i < 9; i++) begin
      chk(req_line, 1'b0);
      host_u.send(8'(8'h40 + i), 1'b1, 1'b1);
    end
    tick(10);
    chk(req_line, 1'b1);
    for (int i = 9; i < 25; i++) host_u.send(8'(8'h40 + i), 1'b1, 1'b0);
    tick(10);
    chk(n_ovr, 0);
    rx_ready = 1'b1;
    tick(40);
    chk(rxq.size(), 25);
    foreach (rxq[i]) chk(rxq[i], 8'h40 + i);
    chk(req_line, 1'b0);
    $display("request line test done");
  endtask

  task automatic t_pd();
    pd_n = 1'b0;
    tick(6);
    chk({tx_oe_n, req_oe_n, link_ready, tx_line, req_line}, 5'h1b);
    pd_n = 1'b1;
    t_power();
    $display("power-down test done");
  endtask

  task automatic end_sim();
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence
  initial begin
    rstn     = 1'b0;
    pd_n     = 1'b1;
    clear    = 1'b1;
    tx_valid = 1'b0;
    tx_data  = 8'h00;
    rx_ready = 1'b1;
    tick(10);
    rstn = 1'b1;
    t_power();
    t_send();
    t_cts();
    t_rx();
    t_rts();
    t_pd();
    end_sim();
  end

  // Runs take under 6000 cycles; this limit cuts a hang short
  initial begin
    #(20000 * 50);
    miscompares++;
    end_sim();
  end
endmodule // tb_top
